// *** hw/fsq_pkg.sv ***
package fsq_pkg;
  // Command codes written on the low data byte
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'hA0;
  localparam logic [7:0] CMD_PROTECT = 8'h60;
  localparam logic [7:0] CMD_VERIFY = 8'h40;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [7:0] CMD_FAST_RESET1 = 8'h90;
  localparam logic [7:0] CMD_FAST_RESET2 = 8'hF0;
  // Unlock and secure-region entry/exit sequences
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_FAST_ENTER = 8'h20;
  localparam logic [7:0] CMD_OTP_ENTER = 8'h88;
  localparam logic [7:0] CMD_OTP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_OTP_EXIT2 = 8'h00;
  // Low address pattern of a protect or verify cycle (bits 6,3,2,1,0)
  localparam logic [6:0] PROT_LOW_ADDR = 7'h02;
  // Secure region word base addresses
  localparam logic [20:0] OTP_TOP_BASE = 21'h1FF000;
  localparam logic [20:0] OTP_BOT_BASE = 21'h000000;
  // Status bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SECTOR_TOGGLE_BIT = 2;
  localparam int PROTECT_VERIFY_BIT = 0;
  // APB register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Bus timing: 70 ns strobe, 30 ns recovery at 20 ns per cycle
  localparam int CLK_NS = 20;
  localparam int STROBE_NS = 70;
  localparam int RECOV_NS = 30;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RECOV_CYC = 4'((RECOV_NS + CLK_NS - 1) / CLK_NS);
  // Host operations taken from the command register
  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_SUSPEND, OP_RESUME, OP_FAST_ENTER, OP_FAST_PROG,
    OP_FAST_EXIT, OP_PROTECT, OP_VERIFY, OP_QUERY, OP_READ_RESET,
    OP_OTP_ENTER, OP_OTP_EXIT, OP_PROGRAM
  } fsq_op_e;
  // One flash bus cycle
  typedef struct packed {
    logic wr;
    logic [20:0] addr;
    logic [15:0] data;
  } fsq_cyc_s;
endpackage

// *** hw/fsq_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1: Suspend only during sector erase or timeout
// RULE2: Resume with 30h; suspend/resume carry bank
// RULE3: Device suspends within maximum suspend latency
// RULE4: Suspended: busy floats, poll one, toggle stops
// RULE5: Host polls suspend inside erasing sector
// RULE6: Extra suspend writes are ignored
// RULE7: Suspend-read: other sectors read normally
// RULE8: Suspended sector reads toggle sector bit
// RULE9: Program allowed during suspend-read, normal status
// RULE10: Poll at program address, toggle in bank
// RULE11: Repeated resumes ignored; suspend again later
// RULE12: Fast mode programs in two cycles
// RULE13: Fast mode: only program or fast reset; host flags others in bad_q but still issues them
// RULE14: Fast program is A0h then address/data
// RULE15: Elevated reset, 60h twice with pattern protects
// RULE16: Verify 40h, bit zero one means protected
// RULE17: Leave protection by returning reset high
// RULE18: Query 98h with bank address
// RULE19: Query upper byte zero; exit by reset command
// RULE20: Secure region 256 bytes over boot sector
// RULE21: Secure routing lasts until exit or reset
// RULE22: Change address or chip select after switch
module fsq_host (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [20:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_n,
  input wire logic [15:0] flash_dq_i,
  input wire logic ready_busy_output,
  output logic elevated_pin_level
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOV, S_NEXT} fsq_st_e;
  fsq_st_e st_q, st_d;
  fsq_pkg::fsq_op_e op_q;
  logic [20:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [2:0] step_q;
  logic [3:0] cnt_q;
  logic busy_q, fast_q, query_q, otp_q, elev_q, prot_ok_q, bad_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;
  logic [2:0] nsteps;
  fsq_pkg::fsq_cyc_s cyc;
  logic [31:0] rd_mux;
  logic acc, wr_acc, go;
  // APB decode; slave answers in the access cycle with no wait
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign go = wr_acc && (paddr == fsq_pkg::REG_CMD) && !busy_q;
  assign rd_mux = (paddr == fsq_pkg::REG_ADDR) ? {11'h000, addr_q} :
                  (paddr == fsq_pkg::REG_WDATA) ? {16'h0000, wdata_q} :
                  (paddr == fsq_pkg::REG_STATUS) ?
                    {24'h000000, bad_q, prot_ok_q, rb_s2_q, elev_q, otp_q, query_q,
                     fast_q, busy_q} :
                  (paddr == fsq_pkg::REG_RDATA) ? {16'h0000, rdata_q} : 32'h00000000;
  // Number of bus cycles per operation
  always_comb begin
    case (op_q)
      fsq_pkg::OP_FAST_PROG: nsteps = 3'd2; // [RULE12] [RULE14]
      fsq_pkg::OP_PROGRAM: nsteps = 3'd4; // [RULE9]
      fsq_pkg::OP_FAST_ENTER, fsq_pkg::OP_OTP_ENTER: nsteps = 3'd3;
      fsq_pkg::OP_OTP_EXIT: nsteps = 3'd4;
      fsq_pkg::OP_FAST_EXIT, fsq_pkg::OP_PROTECT: nsteps = 3'd2; // [RULE15]
      fsq_pkg::OP_VERIFY: nsteps = 3'd2; // [RULE16]
      default: nsteps = 3'd1;
    endcase
  end
  // Bus cycle content for the current step; bank bits ride in addr_q
  always_comb begin
    cyc.wr = 1'b1;
    cyc.addr = addr_q;
    cyc.data = wdata_q;
    case (op_q)
      fsq_pkg::OP_READ: cyc.wr = 1'b0; // [RULE5] [RULE7] [RULE10]
      fsq_pkg::OP_SUSPEND: cyc.data = {8'h00, fsq_pkg::CMD_SUSPEND}; // [RULE1] [RULE2]
      fsq_pkg::OP_RESUME: cyc.data = {8'h00, fsq_pkg::CMD_RESUME}; // [RULE2] [RULE11]
      fsq_pkg::OP_QUERY: cyc.data = {8'h00, fsq_pkg::CMD_QUERY}; // [RULE18]
      fsq_pkg::OP_READ_RESET: cyc.data = {8'h00, fsq_pkg::CMD_READ_RESET}; // [RULE19]
      fsq_pkg::OP_FAST_PROG: begin
        if (step_q == 3'd0) cyc.data = {8'h00, fsq_pkg::CMD_PROG_SETUP}; // [RULE14]
      end
      fsq_pkg::OP_FAST_EXIT: begin
        // First cycle keeps the bank address [RULE13]
        cyc.data = {8'h00, (step_q == 3'd0) ? fsq_pkg::CMD_FAST_RESET1
                                            : fsq_pkg::CMD_FAST_RESET2};
      end
      fsq_pkg::OP_PROTECT, fsq_pkg::OP_VERIFY: begin
        cyc.addr = {addr_q[20:7], fsq_pkg::PROT_LOW_ADDR}; // [RULE15]
        cyc.data = {8'h00, (op_q == fsq_pkg::OP_VERIFY && step_q == 3'd0) ?
                    fsq_pkg::CMD_VERIFY : fsq_pkg::CMD_PROTECT};
        if (op_q == fsq_pkg::OP_VERIFY && step_q == 3'd1) cyc.wr = 1'b0; // [RULE16]
      end
      fsq_pkg::OP_PROGRAM, fsq_pkg::OP_FAST_ENTER, fsq_pkg::OP_OTP_ENTER,
      fsq_pkg::OP_OTP_EXIT: begin
        case (step_q)
          3'd0: begin
            cyc.addr = {9'h000, fsq_pkg::UNLOCK_ADDR1};
            cyc.data = {8'h00, fsq_pkg::UNLOCK_DATA1};
          end
          3'd1: begin
            cyc.addr = {9'h000, fsq_pkg::UNLOCK_ADDR2};
            cyc.data = {8'h00, fsq_pkg::UNLOCK_DATA2};
          end
          3'd2: begin
            cyc.addr = {addr_q[20:12], fsq_pkg::UNLOCK_ADDR1};
            cyc.data = {8'h00,
              (op_q == fsq_pkg::OP_PROGRAM) ? fsq_pkg::CMD_PROG_SETUP :
              (op_q == fsq_pkg::OP_FAST_ENTER) ? fsq_pkg::CMD_FAST_ENTER :
              (op_q == fsq_pkg::OP_OTP_ENTER) ? fsq_pkg::CMD_OTP_ENTER :
              fsq_pkg::CMD_OTP_EXIT1};
          end
          default: begin
            if (op_q == fsq_pkg::OP_OTP_EXIT) cyc.data = {8'h00, fsq_pkg::CMD_OTP_EXIT2};
          end
        endcase
      end
      default: cyc.wr = 1'b1;
    endcase
  end
  // Sequencer: setup, strobe, recovery per bus cycle
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (go) st_d = S_SETUP;
      S_SETUP: st_d = S_STROBE;
      S_STROBE: if (cnt_q == 4'h0) st_d = S_RECOV;
      S_RECOV: if (cnt_q == 4'h0) st_d = S_NEXT;
      S_NEXT: st_d = (step_q + 3'd1 >= nsteps) ? S_IDLE : S_SETUP;
      default: st_d = S_IDLE;
    endcase
  end
  // Pin input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_output;
      rb_s2_q <= rb_s1_q;
    end
  end
  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 21'h000000;
      wdata_q <= 16'h0000;
      op_q <= fsq_pkg::OP_READ;
      elev_q <= 1'b0;
      bad_q <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= 1'b0; // Every transfer completes cleanly
      prdata <= rd_mux;
      if (wr_acc && paddr == fsq_pkg::REG_ADDR) addr_q <= pwdata[20:0];
      if (wr_acc && paddr == fsq_pkg::REG_WDATA) wdata_q <= pwdata[15:0];
      if (go) begin
        op_q <= fsq_pkg::fsq_op_e'(pwdata[3:0]);
        elev_q <= pwdata[8]; // Reset pin level select [RULE15] [RULE17]
        // Flag any op other than fast program or exit issued while fast mode is on
        bad_q <= fast_q && pwdata[3:0] != 4'(fsq_pkg::OP_FAST_PROG) &&
                 pwdata[3:0] != 4'(fsq_pkg::OP_FAST_EXIT); // [RULE13]
      end
    end
  end
  // Flash cycle engine and mode tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      step_q <= 3'd0;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_addr <= 21'h000000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      rdata_q <= 16'h0000;
      fast_q <= 1'b0;
      query_q <= 1'b0;
      otp_q <= 1'b0;
      prot_ok_q <= 1'b0;
      elevated_pin_level <= 1'b0;
    end else begin
      st_q <= st_d;
      elevated_pin_level <= elev_q; // Protect mode ends when this drops [RULE17]
      case (st_q)
        S_IDLE: begin
          step_q <= 3'd0;
          busy_q <= go;
        end
        S_SETUP: begin
          // Chip select toggles every cycle so data after a mode switch is valid [RULE22]
          flash_ce_n <= 1'b0;
          flash_addr <= cyc.addr;
          flash_dq_o <= cyc.data;
          flash_dq_oe_n <= !cyc.wr;
          // Full count: strobe stays low for all STROBE_CYC cycles, never shorter
          cnt_q <= fsq_pkg::STROBE_CYC;
        end
        S_STROBE: begin
          flash_we_n <= !cyc.wr;
          flash_oe_n <= cyc.wr;
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt_q <= fsq_pkg::RECOV_CYC;
            // Synchronised sample, settled during the strobe
            if (!cyc.wr) rdata_q <= dq_s2_q;
          end
        end
        S_RECOV: begin
          flash_dq_oe_n <= 1'b1;
          cnt_q <= cnt_q - 4'h1;
        end
        S_NEXT: begin
          step_q <= step_q + 3'd1;
          if (st_d == S_IDLE) begin
            busy_q <= 1'b0;
            case (op_q)
              fsq_pkg::OP_FAST_ENTER: fast_q <= 1'b1;
              fsq_pkg::OP_FAST_EXIT: fast_q <= 1'b0;
              fsq_pkg::OP_QUERY: query_q <= 1'b1; // [RULE18]
              fsq_pkg::OP_READ_RESET: query_q <= 1'b0; // [RULE19]
              fsq_pkg::OP_OTP_ENTER: otp_q <= 1'b1; // [RULE20] [RULE21]
              fsq_pkg::OP_OTP_EXIT: otp_q <= 1'b0; // [RULE21]
              fsq_pkg::OP_VERIFY: prot_ok_q <= rdata_q[fsq_pkg::PROTECT_VERIFY_BIT]; // [RULE16]
              default: prot_ok_q <= prot_ok_q;
            endcase
          end
        end
        default: busy_q <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/fsq_host_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
// Bus-level checks on the host's APB and flash pins
module fsq_host_assertions (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pready,
  // Flash pins
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_dq_oe_n,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_o
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_WAIT: assert property ($rose(psel) |-> !pready ##1 pready)
    else $error("pready not one cycle after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_WE_OE_APART: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and output strobes overlap");
  AST_STROBE_IN_CE: assert property (!(flash_we_n && flash_oe_n) |-> !flash_ce_n)
    else $error("strobe active without chip select");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe width wrong");
  AST_DQ_DRIVEN: assert property (!flash_we_n |-> !flash_dq_oe_n)
    else $error("data not driven during write");
  AST_NO_CONTENTION: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("host drives data during read");
  AST_WRITE_STABLE: assert property (!flash_we_n && $past(!flash_we_n)
    |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in write strobe");
  AST_CE_RECOVERY: assert property ($rose(flash_ce_n) |-> flash_ce_n [*3])
    else $error("chip select recovery too short");
endmodule
bind fsq_host fsq_host_assertions fsq_host_assertions_inst (.*);
`default_nettype wire

// *** test/fsq_flash_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behavioural flash die: commands decoded on the write strobe, tiny array
module fsq_flash_model #(
  parameter logic [15:0] OTP_WORD = 16'h0A5C // Arbitrary secure-region content
) (
  // Bus pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_w,
  output logic [15:0] dq_r,
  output logic rdy,
  // Board and bench controls
  input wire logic elev,
  input wire logic erase_go
);
  logic [15:0] mem [16];
  logic [15:0] rd;
  logic ers, sus, qry, pgm, prt, ver, otp, tg, t2, p1;
  wire logic in_es = ers && addr[20:16] == 5'h03;
  initial begin
    {ers, sus, qry, pgm, prt, ver, otp, tg, t2, p1} = '0;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  // Read mux; status words come only from the erasing sector
  always_comb begin
    if (ver && elev) rd = {15'h0, prt};
    else if (qry) rd = 16'h0051;
    else if (in_es) rd = {8'h00, sus, sus | tg, 3'h0, t2, 2'h0};
    else if (otp && addr < 21'h80) rd = OTP_WORD;
    else rd = mem[addr[3:0]];
  end
  // Undriven bus shows the inverse so a stale sample cannot pass
  assign dq_r = (!ce_n && !oe_n) ? rd : ~rd;
  // Released busy line is pulled up, so a suspended erase reads as ready
  assign rdy = !(ers && !sus);
  // Sector toggle advances once per read of the erasing sector; the toggle bit only while not suspended
  always @(posedge oe_n) begin
    if (in_es) begin
      tg <= tg ^ !sus;
      t2 <= ~t2;
    end
  end
  always @(posedge erase_go) ers <= 1'b1;
  // Commands are taken on the rising write strobe; unlock bytes fall through
  always @(posedge we_n) begin
    if (pgm) begin
      mem[addr[3:0]] <= dq_w;
      pgm <= 1'b0;
    end else begin
      case (dq_w[7:0])
        8'hB0: sus <= sus | in_es;
        8'h30: sus <= sus & !in_es;
        8'hA0: pgm <= 1'b1;
        8'h98: qry <= 1'b1;
        8'hF0: {qry, ver} <= 2'h0;
        8'h60: if (elev) {prt, p1} <= {prt | p1, ~p1};
        8'h40: ver <= elev;
        8'h88: otp <= 1'b1;
        8'h90: otp <= 1'b0;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/test_fsq_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_fsq_host;
  localparam logic [15:0] OTP_WORD = 16'h0A5C;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic erase_go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic [31:0] seed = 32'h0000B83E; // 47166
  logic pready, pslverr, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n;
  logic ready_busy_output, elevated_pin_level;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_o, dq_r, rv, d1, d2, d3, r1;
  wire logic [15:0] flash_dq_i = flash_dq_oe_n ? dq_r : flash_dq_o;
  int n_fail = 0, checks_done = 0;
  // Free-running 50 MHz bus clock
  always #10 pclk = ~pclk;
  fsq_host fsq_host_inst (.*);
  fsq_flash_model #(.OTP_WORD(OTP_WORD)) fsq_flash_model_inst (.ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .addr(flash_addr), .dq_w(flash_dq_i),
    .dq_r(dq_r), .rdy(ready_busy_output), .elev(elevated_pin_level), .erase_go(erase_go));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic timeout_stop();
    n_fail++;
    report_and_stop();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an extra edge after release keeps strobes single-assigned
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout_stop();
    @(posedge pclk);
  endtask
  task automatic st();
    apb(1'b0, fsq_pkg::REG_STATUS, 32'h0, v);
  endtask
  // Issue one host operation, wait until idle, fetch the last read word
  task automatic op(input logic [8:0] c, input logic [20:0] a, input logic [15:0] d);
    int i;
    apb(1'b1, fsq_pkg::REG_ADDR, {11'h0, a}, v);
    apb(1'b1, fsq_pkg::REG_WDATA, {16'h0, d}, v);
    apb(1'b1, fsq_pkg::REG_CMD, {23'h0, c}, v);
    i = 0;
    do begin
      st();
      i++;
    end while (v[0] !== 1'b0 && i < 200);
    if (v[0] !== 1'b0) timeout_stop();
    apb(1'b0, fsq_pkg::REG_RDATA, 32'h0, v);
    rv = v[15:0];
  endtask
  task automatic rdw(input logic [20:0] a);
    op(9'h000, a, 16'h0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st();
    chk(v[15:0], 16'h0020);
    apb(1'b0, 8'h40, 32'h0, v);
    chk(v[15:0], 16'h0000);
    d1 = rnd();
    d2 = rnd();
    d3 = rnd();
    op(9'h002, 21'h030000, 16'h0);
    op(9'h00D, 21'h010001, d1);
    erase_go <= 1'b1;
    rdw(21'h030000);
    chk(rv & 16'h0080, 16'h0000);
    st();
    chk(v[15:0] & 16'h0020, 16'h0000);
    op(9'h002, 21'h030000, 16'h0);
    op(9'h002, 21'h030000, 16'h0);
    rdw(21'h030000); // confirm inside the erasing sector
    r1 = rv;
    rdw(21'h030004);
    chk(rv & 16'h00C0, 16'h00C0);
    chk((rv ^ r1) & 16'h0044, 16'h0004);
    st();
    chk(v[15:0] & 16'h0020, 16'h0020);
    op(9'h00D, 21'h020002, d2); // status left to the read below
    rdw(21'h020002);
    chk(rv, d2);
    rdw(21'h010001);
    chk(rv, d1);
    op(9'h003, 21'h030000, 16'h0);
    op(9'h003, 21'h030000, 16'h0);
    st();
    chk(v[15:0] & 16'h0020, 16'h0000);
    op(9'h002, 21'h030000, 16'h0);
    st();
    chk(v[15:0] & 16'h0020, 16'h0020);
    op(9'h009, 21'h010000, 16'h0);
    rdw(21'h010010);
    chk(rv & 16'hFF00, 16'h0000);
    op(9'h00A, 21'h010000, 16'h0);
    rdw(21'h010001);
    chk(rv, d1);
    op(9'h004, 21'h000000, 16'h0);
    st();
    chk(v[15:0] & 16'h0082, 16'h0002);
    op(9'h005, 21'h020003, d3); // only fast commands in this mode
    op(9'h006, 21'h020000, 16'h0);
    rdw(21'h020003);
    chk(rv, d3);
    op(9'h107, 21'h050000, 16'h0);
    op(9'h108, 21'h050000, 16'h0);
    chk(rv & 16'h0001, 16'h0001);
    st();
    chk(v[15:0] & 16'h0050, 16'h0050);
    rdw(21'h050000);
    chk(rv, 16'hFFFF);
    op(9'h00B, 21'h000000, 16'h0);
    rdw(21'h00007F);
    chk(rv, OTP_WORD);
    rdw(21'h000080);
    chk(rv, 16'hFFFF);
    op(9'h00C, 21'h000000, 16'h0);
    rdw(21'h000020); // new address after the switch
    chk(rv, 16'hFFFF);
    report_and_stop();
  end
endmodule
`default_nettype wire
